// file: verilog/cgsb_ctrl_bank.sv
// Operation
// - Block write: index, count, data stored consecutively
// - Block read: count byte first, then data
// - Target address from strap at power-good
// - Enable bit zero forces pair low
// - Strap readback in byte 1 bits 7:6
// - Override bit lets software select spread
// - Software spread code: off, -0.25%, -0.5%
// - Software spread ineffective without override bit
// - Amplitude field, resets to 10
// - Per-pair edge speed, zero slow, one fast
// - Reference edge rate field, resets to 01
// - Wake bit keeps reference running in power-down
// - Reference enable bit, zero holds it low
// - Byte 5 fixed revision and vendor codes
// - Byte 6 fixed device type and identifier
// - Byte 7 sets block read length
`timescale 1ns/10ps
module cgsb_ctrl_bank
  import cgsb_pkg::*;
#(
  parameter logic [3:0] REVISION_CODE = 4'h3, // Arbitrary value.
  parameter logic [3:0] VENDOR_CODE   = 4'ha, // Arbitrary value.
  parameter logic [1:0] DEVICE_TYPE   = 2'h2, // Arbitrary value.
  parameter logic [5:0] DEVICE_CODE   = 6'h2a // Arbitrary value.
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n_out,
  input  wire logic       bus_address_strap_in,
  input  wire logic [1:0] spread_strap_in,
  input  wire logic       powergood_powerdown_pin_in,
  input  wire logic [5:0] pair_enable_pin_n_in,
  output logic      [5:0] pair_clock_enable_out,
  output logic      [5:0] pair_edge_speed_out,
  output logic      [1:0] spread_select_out,
  output logic      [1:0] amplitude_select_out,
  output logic      [1:0] ref_edge_rate_out,
  output logic            ref_run_out,
  output logic            ref_float_out
);

  logic        scl_s;
  logic        sda_s;
  logic        addr_strap_s;
  logic [1:0]  spread_strap_s;
  logic        pg_s;
  logic [5:0]  pin_n_s;
  logic        pg_seen;
  logic        addr_bit;
  logic [1:0]  strap_code;

  cgsb_sync #(
    .WIDTH  (12),
    .STAGES (2)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .async_in ({scl_in, sda_in, bus_address_strap_in, spread_strap_in,
                powergood_powerdown_pin_in, pair_enable_pin_n_in}),
    .sync_out ({scl_s, sda_s, addr_strap_s, spread_strap_s, pg_s, pin_n_s})
  );

  cgsb_strap_latch u_strap (
    .clk_in          (clk_in),
    .rst_n_in        (rst_n_in),
    .powergood_in    (pg_s),
    .addr_strap_in   (addr_strap_s),
    .spread_strap_in (spread_strap_s),
    .seen_out        (pg_seen),
    .addr_bit_out    (addr_bit),
    .spread_code_out (strap_code)
  );

  // Edge and bus-condition detection on the synchronised serial lines.
  logic scl_q_reg;
  logic sda_q_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      scl_q_reg <= scl_s;
      sda_q_reg <= sda_s;
    end
  end

  assign scl_rise  = scl_s && !scl_q_reg;
  assign scl_fall  = !scl_s && scl_q_reg;
  assign start_det = scl_s && scl_q_reg && sda_q_reg && !sda_s;
  assign stop_det  = scl_s && scl_q_reg && !sda_q_reg && sda_s;

  // Register storage.
  logic [7:0] oe_reg;
  logic [7:0] ctrl1_reg;
  logic [7:0] slew_reg;
  logic [7:0] refc_reg;
  logic [7:0] len_reg;

  function automatic logic [7:0] reg_read(input logic [7:0] idx);
    logic [7:0] val;
    val = 8'h00;
    if (idx == CGSB_IDX_OE) begin
      val = oe_reg & CGSB_PAIR_MASK;
    end else if (idx == CGSB_IDX_CTRL1) begin
      val = (ctrl1_reg & CGSB_CTRL1_MASK) | CGSB_CTRL1_RSVD;
      val[CGSB_STRAP_LSB +: 2] = strap_code;
    end else if (idx == CGSB_IDX_SLEW) begin
      val = slew_reg & CGSB_PAIR_MASK;
    end else if (idx == CGSB_IDX_REFC) begin
      val = (refc_reg & CGSB_REFC_MASK) | CGSB_REFC_RSVD;
    end else if (idx == CGSB_IDX_REVID) begin
      val = {REVISION_CODE, VENDOR_CODE};
    end else if (idx == CGSB_IDX_DEVID) begin
      val = {DEVICE_TYPE, DEVICE_CODE};
    end else if (idx == CGSB_IDX_LEN) begin
      val = len_reg & CGSB_LEN_MASK;
    end
    return val;
  endfunction

  // Serial target state.
  cgsb_state_t state_reg;
  cgsb_state_t after_ack_reg;
  logic [7:0]  shift_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  idx_reg;
  logic [7:0]  wr_left_reg;
  logic [4:0]  rd_left_reg;
  logic        read_dir_reg;
  logic        host_ack_reg;
  logic        sda_drive_reg;
  logic        byte_done;
  logic        wr_stb;
  logic [6:0]  own_addr;
  logic [7:0]  next_rd_byte;

  assign own_addr  = CGSB_ADDR_BASE | (7'(addr_bit) << CGSB_ADDR_STRAP_BIT);
  assign byte_done = scl_fall && (bit_cnt_reg == CGSB_BYTE_BITS);
  assign wr_stb    = (state_reg == CGSB_ST_WDATA) && byte_done && (wr_left_reg != 8'h00);
  // Past the programmed length the target lets the line float high.
  assign next_rd_byte = (rd_left_reg != 5'h00) ? reg_read(idx_reg) : CGSB_IDLE_BYTE;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg     <= CGSB_ST_IDLE;
      after_ack_reg <= CGSB_ST_IDLE;
      shift_reg     <= 8'h00;
      bit_cnt_reg   <= 4'h0;
      idx_reg       <= 8'h00;
      wr_left_reg   <= 8'h00;
      rd_left_reg   <= 5'h00;
      read_dir_reg  <= 1'b0;
      host_ack_reg  <= 1'b0;
      sda_drive_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg     <= CGSB_ST_IDLE;
      sda_drive_reg <= 1'b0;
    end else if (start_det && pg_seen) begin
      // A repeated start keeps the index written before it.
      state_reg     <= CGSB_ST_ADDR;
      bit_cnt_reg   <= 4'h0;
      sda_drive_reg <= 1'b0;
    end else begin
      case (state_reg)
        CGSB_ST_ADDR, CGSB_ST_CMD, CGSB_ST_COUNT, CGSB_ST_WDATA: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_done) begin
            bit_cnt_reg   <= 4'h0;
            sda_drive_reg <= 1'b1;
            state_reg     <= CGSB_ST_ACK;
            if (state_reg == CGSB_ST_ADDR) begin
              read_dir_reg  <= shift_reg[0];
              after_ack_reg <= shift_reg[0] ? CGSB_ST_RDATA : CGSB_ST_CMD;
              if (shift_reg[7:1] != own_addr) begin
                sda_drive_reg <= 1'b0;
                state_reg     <= CGSB_ST_IDLE;
              end
            end else if (state_reg == CGSB_ST_CMD) begin
              idx_reg       <= shift_reg;
              after_ack_reg <= CGSB_ST_COUNT;
            end else if (state_reg == CGSB_ST_COUNT) begin
              wr_left_reg   <= shift_reg;
              after_ack_reg <= CGSB_ST_WDATA;
            end else begin
              after_ack_reg <= CGSB_ST_WDATA;
              if (wr_left_reg != 8'h00) begin
                idx_reg     <= idx_reg + 8'h01;
                wr_left_reg <= wr_left_reg - 8'h01;
              end
            end
          end
        end
        CGSB_ST_ACK: begin
          if (scl_fall) begin
            state_reg   <= after_ack_reg;
            bit_cnt_reg <= 4'h0;
            if (after_ack_reg == CGSB_ST_RDATA) begin
              // The first byte of a read is the programmed length.
              shift_reg     <= len_reg & CGSB_LEN_MASK;
              rd_left_reg   <= len_reg[4:0];
              sda_drive_reg <= ~len_reg[7];
            end else begin
              sda_drive_reg <= 1'b0;
            end
          end
        end
        CGSB_ST_RDATA: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_done) begin
            sda_drive_reg <= 1'b0;
            state_reg     <= CGSB_ST_HACK;
          end else if (scl_fall) begin
            shift_reg     <= {shift_reg[6:0], 1'b0};
            sda_drive_reg <= ~shift_reg[6];
          end
        end
        CGSB_ST_HACK: begin
          if (scl_rise) begin
            host_ack_reg <= !sda_s;
          end else if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (host_ack_reg) begin
              shift_reg     <= next_rd_byte;
              sda_drive_reg <= ~next_rd_byte[7];
              state_reg     <= CGSB_ST_RDATA;
              if (rd_left_reg != 5'h00) begin
                idx_reg     <= idx_reg + 8'h01;
                rd_left_reg <= rd_left_reg - 5'h01;
              end
            end else begin
              state_reg <= CGSB_ST_IDLE;
            end
          end
        end
        default: begin
          sda_drive_reg <= 1'b0;
        end
      endcase
    end
  end

  assign sda_out      = 1'b0;
  assign sda_oe_n_out = ~sda_drive_reg;

  // Register writes; read-only and reserved bits are masked off here.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      oe_reg    <= CGSB_OE_RST;
      ctrl1_reg <= CGSB_CTRL1_RST;
      slew_reg  <= CGSB_SLEW_RST;
      refc_reg  <= CGSB_REFC_RST;
      len_reg   <= CGSB_LEN_RST;
    end else if (wr_stb) begin
      if (idx_reg == CGSB_IDX_OE) begin
        oe_reg <= shift_reg & CGSB_PAIR_MASK;
      end else if (idx_reg == CGSB_IDX_CTRL1) begin
        ctrl1_reg <= shift_reg & CGSB_CTRL1_MASK;
      end else if (idx_reg == CGSB_IDX_SLEW) begin
        slew_reg <= shift_reg & CGSB_PAIR_MASK;
      end else if (idx_reg == CGSB_IDX_REFC) begin
        refc_reg <= shift_reg & CGSB_REFC_MASK;
      end else if (idx_reg == CGSB_IDX_LEN) begin
        len_reg <= shift_reg & CGSB_LEN_MASK;
      end
    end
  end

  // Output controls.
  logic [5:0] pair_oe_vec;
  logic [5:0] pair_slew_vec;
  logic       ref_on_next;

  for (genvar p = 0; p < CGSB_NUM_PAIRS; p++) begin : g_pair
    assign pair_oe_vec[p]   = oe_reg[CGSB_PAIR_POS[p]];
    assign pair_slew_vec[p] = slew_reg[CGSB_PAIR_POS[p]];
  end

  // Power-down low stops everything except a reference kept alive for wake.
  assign ref_on_next = refc_reg[CGSB_REF_OE_BIT] &&
                       (pg_s || refc_reg[CGSB_WOL_BIT]);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pair_clock_enable_out <= 6'h00;
      pair_edge_speed_out   <= 6'h3f;
      spread_select_out     <= CGSB_SS_OFF;
      amplitude_select_out  <= CGSB_CTRL1_RST[1:0];
      ref_edge_rate_out     <= CGSB_REFC_RST[7:6];
      ref_run_out           <= 1'b0;
      ref_float_out         <= 1'b1;
    end else begin
      pair_clock_enable_out <= pair_oe_vec & ~pin_n_s & {6{pg_s}};
      pair_edge_speed_out   <= pair_slew_vec;
      // The software code is stored always but only steers spread under override.
      spread_select_out     <= ctrl1_reg[CGSB_OVR_BIT] ?
                               ctrl1_reg[CGSB_SW_LSB +: 2] : strap_code;
      amplitude_select_out  <= ctrl1_reg[CGSB_AMP_LSB +: 2];
      ref_edge_rate_out     <= refc_reg[CGSB_REF_RATE_LSB +: 2];
      ref_run_out           <= ref_on_next && pg_seen;
      ref_float_out         <= !pg_seen;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  property p_pair_forced_low;
    (pair_clock_enable_out & ~$past(pair_oe_vec)) == 6'h00;
  endproperty
  a_pair_forced_low: assert property (p_pair_forced_low)
    else $error("pair enabled while its enable bit is zero");

  property p_strap_readback;
    reg_read(CGSB_IDX_CTRL1) >> CGSB_STRAP_LSB == {6'h00, strap_code};
  endproperty
  a_strap_readback: assert property (p_strap_readback)
    else $error("spread strap readback mismatch");

  property p_sw_ignored;
    !ctrl1_reg[CGSB_OVR_BIT] |=> spread_select_out == $past(strap_code);
  endproperty
  a_sw_ignored: assert property (p_sw_ignored)
    else $error("software spread used without override");

  property p_sw_used;
    ctrl1_reg[CGSB_OVR_BIT] ##1 ctrl1_reg[CGSB_OVR_BIT]
      |-> spread_select_out == $past(ctrl1_reg[4:3]);
  endproperty
  a_sw_used: assert property (p_sw_used)
    else $error("override set but software spread not applied");

  property p_readonly_kept;
    wr_stb && idx_reg == CGSB_IDX_CTRL1 |=> reg_read(CGSB_IDX_CTRL1) >> 6 == $past(strap_code);
  endproperty
  a_readonly_kept: assert property (p_readonly_kept)
    else $error("write changed read-only strap bits");

  property p_reserved_zero;
    reg_read(CGSB_IDX_RSVD) == 8'h00 && len_reg[7:5] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits not reading default");

  property p_write_advance;
    wr_stb |=> idx_reg == $past(idx_reg) + 8'h01 && state_reg == CGSB_ST_ACK;
  endproperty
  a_write_advance: assert property (p_write_advance)
    else $error("index not advanced after data byte");

  property p_ack_drive;
    state_reg == CGSB_ST_ACK |-> !sda_oe_n_out;
  endproperty
  a_ack_drive: assert property (p_ack_drive)
    else $error("acknowledge slot not driven low");

  property p_ref_off;
    !refc_reg[CGSB_REF_OE_BIT] |=> !ref_run_out;
  endproperty
  a_ref_off: assert property (p_ref_off)
    else $error("reference runs while disabled");

  property p_wol;
    pg_seen && !pg_s && !refc_reg[CGSB_WOL_BIT] |=> !ref_run_out;
  endproperty
  a_wol: assert property (p_wol)
    else $error("reference runs in power-down without wake bit");

  c_write: cover property (wr_stb ##[1:200] wr_stb);
  c_read: cover property (state_reg == CGSB_ST_HACK ##[1:20] state_reg == CGSB_ST_RDATA);
  c_override: cover property ($rose(ctrl1_reg[CGSB_OVR_BIT]));
  c_pair_off: cover property (pg_s && pair_clock_enable_out != 6'h3f);

endmodule // cgsb_ctrl_bank

// file: verilog/cgsb_pkg.sv
package cgsb_pkg;

  // Register indices.
  localparam logic [7:0] CGSB_IDX_OE    = 8'h00;
  localparam logic [7:0] CGSB_IDX_CTRL1 = 8'h01;
  localparam logic [7:0] CGSB_IDX_SLEW  = 8'h02;
  localparam logic [7:0] CGSB_IDX_REFC  = 8'h03;
  localparam logic [7:0] CGSB_IDX_RSVD  = 8'h04;
  localparam logic [7:0] CGSB_IDX_REVID = 8'h05;
  localparam logic [7:0] CGSB_IDX_DEVID = 8'h06;
  localparam logic [7:0] CGSB_IDX_LEN   = 8'h07;

  // Pair bits in the enable and edge-speed bytes; bits 5 and 1 are reserved.
  localparam int         CGSB_NUM_PAIRS             = 6;
  localparam int         CGSB_PAIR_POS [0:5]        = '{0, 2, 3, 4, 6, 7};
  localparam logic [7:0] CGSB_PAIR_MASK             = 8'hdd;
  localparam logic [7:0] CGSB_OE_RST                = 8'hdd;
  localparam logic [7:0] CGSB_SLEW_RST              = 8'hdd;

  // Spread and amplitude byte.
  localparam logic [7:0] CGSB_CTRL1_MASK            = 8'h3b;
  localparam logic [7:0] CGSB_CTRL1_RST             = 8'h02;
  localparam logic [7:0] CGSB_CTRL1_RSVD            = 8'h04;
  localparam int         CGSB_STRAP_LSB             = 6;
  localparam int         CGSB_OVR_BIT               = 5;
  localparam int         CGSB_SW_LSB                = 3;
  localparam int         CGSB_AMP_LSB               = 0;

  // Reference output byte.
  localparam logic [7:0] CGSB_REFC_MASK             = 8'hf0;
  localparam logic [7:0] CGSB_REFC_RST              = 8'h50;
  localparam logic [7:0] CGSB_REFC_RSVD             = 8'h0d;
  localparam int         CGSB_REF_RATE_LSB          = 6;
  localparam int         CGSB_WOL_BIT               = 5;
  localparam int         CGSB_REF_OE_BIT            = 4;

  // Readback length byte.
  localparam logic [7:0] CGSB_LEN_MASK              = 8'h1f;
  localparam logic [7:0] CGSB_LEN_RST               = 8'h08;

  // Spread codes, shared by strap and software select.
  localparam logic [1:0] CGSB_SS_OFF                = 2'h0;
  localparam logic [1:0] CGSB_SS_MID                = 2'h1;
  localparam logic [1:0] CGSB_SS_HIGH               = 2'h3;

  // Bus target address, strap picks bit 1.
  localparam logic [6:0] CGSB_ADDR_BASE             = 7'h68;
  localparam int         CGSB_ADDR_STRAP_BIT        = 1;
  localparam logic [3:0] CGSB_BYTE_BITS             = 4'h8;
  localparam logic [7:0] CGSB_IDLE_BYTE             = 8'hff;

  typedef enum logic [2:0] {
    CGSB_ST_IDLE,
    CGSB_ST_ADDR,
    CGSB_ST_CMD,
    CGSB_ST_COUNT,
    CGSB_ST_WDATA,
    CGSB_ST_ACK,
    CGSB_ST_RDATA,
    CGSB_ST_HACK
  } cgsb_state_t;

endpackage

// file: verilog/cgsb_sync.sv
`timescale 1ns/10ps
module cgsb_sync
  import cgsb_pkg::*;
#(
  parameter int WIDTH  = 1,
  parameter int STAGES = 2
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  if (STAGES < 2) begin : g_check
    $error("cgsb_sync needs at least two stages");
  end

  logic [WIDTH-1:0] stage_reg [STAGES];

  // Only the next stage reads each flop, so no logic sees a metastable level.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_reg[i] <= '0;
      end
    end else begin
      stage_reg[0] <= async_in;
      for (int i = 1; i < STAGES; i++) begin
        stage_reg[i] <= stage_reg[i-1];
      end
    end
  end

  assign sync_out = stage_reg[STAGES-1];

endmodule // cgsb_sync

// file: verilog/cgsb_strap_latch.sv
`timescale 1ns/10ps
module cgsb_strap_latch
  import cgsb_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       powergood_in,
  input  wire logic       addr_strap_in,
  input  wire logic [1:0] spread_strap_in,
  output logic            seen_out,
  output logic            addr_bit_out,
  output logic [1:0]      spread_code_out
);

  logic       seen_reg;
  logic       addr_reg;
  logic [1:0] spread_reg;

  // Straps are caught once, on the first power-good high after reset.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      seen_reg   <= 1'b0;
      addr_reg   <= 1'b0;
      spread_reg <= CGSB_SS_OFF;
    end else if (powergood_in && !seen_reg) begin
      seen_reg   <= 1'b1;
      addr_reg   <= addr_strap_in;
      // An impossible comparator code 10 is folded onto mid level.
      spread_reg <= (spread_strap_in == 2'h2) ? CGSB_SS_MID : spread_strap_in;
    end
  end

  assign seen_out        = seen_reg;
  assign addr_bit_out    = addr_reg;
  assign spread_code_out = spread_reg;

endmodule // cgsb_strap_latch

// file: tb/cgsb_host.sv
`timescale 1ns/10ps
module cgsb_host (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_out
);
  // The serial clock idles high between frames and the data line starts released.
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  task automatic hp(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // Data moves one clock after the serial clock falls, so the target's synchronisers
  // never see both lines change together and mistake it for a start or stop.
  task automatic clk_bit(input logic b, output logic s);
    hp(1);
    sda_out <= b;
    hp(3);
    scl_out <= 1'b1;
    hp(4);
    s = sda_in;
    scl_out <= 1'b0;
  endtask

  task automatic gen_start();
    hp(1);
    sda_out <= 1'b1;
    hp(3);
    scl_out <= 1'b1;
    hp(4);
    sda_out <= 1'b0;
    hp(4);
    scl_out <= 1'b0;
  endtask

  task automatic gen_stop();
    hp(1);
    sda_out <= 1'b0;
    hp(3);
    scl_out <= 1'b1;
    hp(4);
    sda_out <= 1'b1;
    hp(4);
  endtask

  task automatic send(input logic [7:0] d, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'b1, ack_n);
  endtask

  task automatic recv(input logic ack_n, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(ack_n, s);
  endtask
endmodule // cgsb_host

// file: tb/test_clock_gen_smbus_control_bank.sv
`timescale 1ns/10ps
module test_clock_gen_smbus_control_bank
  import cgsb_pkg::*;
();
  localparam logic [3:0] REV   = 4'h5; // Arbitrary value.
  localparam logic [3:0] VEN   = 4'hc; // Arbitrary value.
  localparam logic [1:0] DTYPE = 2'h1; // Arbitrary value.
  localparam logic [5:0] DCODE = 6'h15; // Arbitrary value.
  localparam logic [7:0] ID5   = {REV, VEN};
  localparam logic [7:0] ID6   = {DTYPE, DCODE};
  localparam logic [7:0] ADR_W = {CGSB_ADDR_BASE, 1'b0};
  localparam int         LIMIT = 30000;

  logic       clk, rst_n, pg, addr_strap, scl, host_sda, dut_sda, dut_oe_n, ref_run, ref_float;
  logic [1:0] sp_strap, spread, amp, ref_rate, sw, am;
  logic [5:0] pin_n, pair_en, edge_spd;
  wire        sda_wire = host_sda & (dut_oe_n ? 1'b1 : dut_sda);
  int         n_fail = 0;
  int         cmp_count = 0;
  int         cyc = 0;

  cgsb_ctrl_bank #(.REVISION_CODE(REV), .VENDOR_CODE(VEN), .DEVICE_TYPE(DTYPE),
                   .DEVICE_CODE(DCODE)) u_dut (
    .clk_in(clk), .rst_n_in(rst_n), .scl_in(scl), .sda_in(sda_wire), .sda_out(dut_sda),
    .sda_oe_n_out(dut_oe_n), .bus_address_strap_in(addr_strap), .spread_strap_in(sp_strap),
    .powergood_powerdown_pin_in(pg), .pair_enable_pin_n_in(pin_n),
    .pair_clock_enable_out(pair_en), .pair_edge_speed_out(edge_spd),
    .spread_select_out(spread), .amplitude_select_out(amp), .ref_edge_rate_out(ref_rate),
    .ref_run_out(ref_run), .ref_float_out(ref_float));

  cgsb_host u_host (.clk_in(clk), .sda_in(sda_wire), .scl_out(scl), .sda_out(host_sda));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      $display("[ERR] %0t run took too long", $time);
      wrap_up();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] idx, input logic [7:0] d[$],
                    input logic exp_nak);
    logic a;
    logic any;
    u_host.gen_start();
    u_host.send(adr, any);
    u_host.send(idx, a);
    any = any | a;
    u_host.send(8'(d.size()), a);
    any = any | a;
    foreach (d[i]) begin
      u_host.send(d[i], a);
      any = any | a;
    end
    u_host.gen_stop();
    chk({7'h00, any}, {7'h00, exp_nak}, "write acknowledge");
  endtask

  // The first expected byte is the count byte; a not-acknowledge ends after the last one.
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp[$]);
    logic       a;
    logic [7:0] b;
    u_host.gen_start();
    u_host.send(ADR_W, a);
    u_host.send(idx, a);
    u_host.gen_start();
    u_host.send(ADR_W | 8'h01, a);
    chk({7'h00, a}, 8'h00, "read acknowledge");
    foreach (exp[i]) begin
      u_host.recv(i == exp.size() - 1, b);
      chk(b, exp[i], "read byte");
    end
    u_host.gen_stop();
  endtask

  task automatic pg_set(input logic v);
    pg <= v;
    repeat (8) @(posedge clk);
  endtask

  initial begin
    rst_n = 1'b0;
    pg = 1'b0;
    addr_strap = 1'b0;
    sp_strap = CGSB_SS_MID;
    pin_n = 6'h00;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    pg_set(1'b1);
    chk({2'h0, pair_en}, 8'h3f, "pair enables");
    chk({2'h0, edge_spd}, 8'h3f, "edge speeds");
    chk({spread, amp, ref_rate, ref_run, ref_float}, 8'h66, "control outputs");
    rd(8'h00, '{8'h08, 8'hdd, 8'h46, 8'hdd, 8'h5d, 8'h00, ID5, ID6, 8'h08});
    $display("test reset_values done");
    wr(ADR_W, 8'h00, '{8'h5c}, 1'b0);
    pin_n <= 6'h02;
    repeat (6) @(posedge clk);
    chk({2'h0, pair_en}, 8'h1c, "pair gating");
    $display("test pair_enable done");
    wr(ADR_W, 8'h01, '{8'h18}, 1'b0);
    chk({4'h0, spread, amp}, 8'h04, "spread without override");
    for (int i = 0; i < 4; i++) begin
      sw = (i == 0) ? CGSB_SS_OFF : (i == 1) ? CGSB_SS_MID : CGSB_SS_HIGH;
      am = 2'(i);
      wr(ADR_W, 8'h01, '{8'he0 | {3'h0, sw, 3'h0} | {6'h00, am}}, 1'b0);
      chk({4'h0, spread, amp}, {4'h0, sw, am}, "spread and amplitude");
      rd(8'h01, '{8'h08, 8'h64 | {3'h0, sw, 3'h0} | {6'h00, am}});
    end
    $display("test spread_amplitude done");
    wr(ADR_W, 8'h02, '{8'h01, 8'hef}, 1'b0);
    chk({2'h0, edge_spd}, 8'h01, "edge speed write");
    chk({5'h00, ref_rate, ref_run}, 8'h06, "reference disabled");
    rd(8'h03, '{8'h08, 8'hed});
    wr(ADR_W, 8'h03, '{8'h70}, 1'b0);
    pg_set(1'b0);
    chk({1'b0, ref_run, pair_en}, 8'h40, "reference kept in power-down");
    pg_set(1'b1);
    wr(ADR_W, 8'h03, '{8'h50}, 1'b0);
    pg_set(1'b0);
    chk({1'b0, ref_run, pair_en}, 8'h00, "reference stopped in power-down");
    pg_set(1'b1);
    $display("test reference_control done");
    wr(ADR_W, 8'h04, '{8'hff, 8'h00, 8'h00}, 1'b0);
    rd(8'h04, '{8'h08, 8'h00, ID5, ID6});
    wr(ADR_W, 8'h07, '{8'he3}, 1'b0);
    rd(8'h05, '{8'h03, ID5, ID6, 8'h03, 8'hff});
    $display("test read_only_and_length done");
    wr({CGSB_ADDR_BASE | 7'h02, 1'b0}, 8'h00, '{8'h00}, 1'b1);
    rd(8'h00, '{8'h03, 8'h5c, 8'h7f, 8'h01});
    $display("test foreign_address done");
    rst_n <= 1'b0;
    pg <= 1'b0;
    addr_strap <= 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    pg_set(1'b1);
    wr({CGSB_ADDR_BASE | 7'h02, 1'b0}, 8'h01, '{8'h01}, 1'b0);
    chk({6'h00, amp}, 8'h01, "amplitude at strapped address");
    wr(ADR_W, 8'h01, '{8'h03}, 1'b1);
    chk({6'h00, amp}, 8'h01, "old address ignored");
    $display("test strapped_address done");
    wrap_up();
  end
endmodule // test_clock_gen_smbus_control_bank
